// ===== parallel_port_pkg.sv
package parallel_port_pkg;
   localparam int          ADDR_W          = 8;
   // register byte addresses
   localparam logic [7:0]  OFF_CONFIG      = 8'h00;
   localparam logic [7:0]  OFF_PORT0       = 8'h04;
   localparam logic [7:0]  OFF_PORT1       = 8'h08;
   localparam logic [7:0]  OFF_PORT2       = 8'h0C;
   localparam logic [7:0]  OFF_PIN_CONFIG  = 8'h10;
   localparam logic [7:0]  OFF_PIN_OUT     = 8'h14;
   localparam logic [7:0]  OFF_INT_STATUS  = 8'h18;
   localparam logic [7:0]  OFF_INT_MASK    = 8'h1C;
   // register indices
   localparam logic [2:0]  IDX_CONFIG      = 3'd0;
   localparam logic [2:0]  IDX_PORT0       = 3'd1;
   localparam logic [2:0]  IDX_PORT1       = 3'd2;
   localparam logic [2:0]  IDX_PORT2       = 3'd3;
   localparam logic [2:0]  IDX_PIN_CONFIG  = 3'd4;
   localparam logic [2:0]  IDX_PIN_OUT     = 3'd5;
   localparam logic [2:0]  IDX_INT_STATUS  = 3'd6;
   localparam logic [2:0]  IDX_INT_MASK    = 3'd7;
   // configuration register fields
   localparam int          CFG_WIDTH_LSB   = 0;
   localparam int          CFG_OV_BIT      = 2;
   localparam int          CFG_IS_BIT      = 3;
   localparam int          CFG_OV_POL_BIT  = 4;
   localparam int          CFG_IS_POL_BIT  = 5;
   localparam int          CFG_ENABLE_BIT  = 6;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [7:0]  CFG_WRITE_MASK  = 8'h73;
   // width codes
   localparam logic [1:0]  WIDTH_8         = 2'b00;
   localparam logic [1:0]  WIDTH_16        = 2'b01;
   // pin configuration: bits 3..2 drive enables, bit 7 pull-down enable
   localparam int          PIN_PD_BIT      = 7;
   localparam logic [7:0]  PIN_CONFIG_RESET = 8'h00;
   localparam logic [7:0]  PIN_OUT_RESET   = 8'h00;
   // interrupt status bits
   localparam int          IRQ_READ_BIT    = 0;
   localparam int          IRQ_WRITE_BIT   = 1;
   localparam logic [1:0]  IRQ_RESET       = 2'b00;
   // bus responses
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage : parallel_port_pkg

// ===== assisted_parallel_port.sv
// What this block does
// R1: width 8, 16 or 24 via config bits 1:0
// R2: enabled port overrides general pin configuration
// R3: enabled: outputs push-pull, inputs no pull-down
// R4: drive input-space flag pin as output
// R5: drive output-valid flag pin as output
// R6: write strobe latches incoming data
// R7: read enable drives latched output data
// R8: select gates both strobe and read enable
// R9: output-valid set by port 0 write, cleared by read
// R10: input-space set by port 0 read, cleared by strobe
// R11: output-valid polarity bit, status opposite pin
// R12: input-space polarity bit, status opposite pin
// R13: read enable plus select drives data pins
// R14: read enable rising raises interrupt
// R15: strobe plus select fills latches, clears space
// R16: strobe rising raises interrupt
// R17: port 0 written last signals data ready
// R18: port 0 read last signals space available
// R19: port 0 low byte, ports 1, 2 upper bytes
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
module assisted_parallel_port
   import parallel_port_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              clk_en,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [23:0]       data_in,
   output logic [23:0]            data_out,
   output logic [23:0]            data_oe,
   input  wire logic              write_strobe_n,
   input  wire logic              read_enable_n,
   input  wire logic              select_n,
   output logic                   input_space_flag_pin,
   output logic                   input_space_flag_oe,
   output logic                   output_valid_flag_pin,
   output logic                   output_valid_flag_oe,
   output logic [2:0]             input_pulldown_en,
   output logic                   irq
);

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
      logic [3:0] r;
      r = 4'b0000;
      unique case (a)
         OFF_CONFIG:     r = {1'b1, IDX_CONFIG};
         OFF_PORT0:      r = {1'b1, IDX_PORT0};
         OFF_PORT1:      r = {1'b1, IDX_PORT1};
         OFF_PORT2:      r = {1'b1, IDX_PORT2};
         OFF_PIN_CONFIG: r = {1'b1, IDX_PIN_CONFIG};
         OFF_PIN_OUT:    r = {1'b1, IDX_PIN_OUT};
         OFF_INT_STATUS: r = {1'b1, IDX_INT_STATUS};
         OFF_INT_MASK:   r = {1'b1, IDX_INT_MASK};
         default:        r = 4'b0000;
      endcase
      return r;
   endfunction : decode

   // pin synchronisers
   logic [23:0] data_meta;
   logic [23:0] data_sync;
   logic [2:0]  ctl_meta;
   logic [2:0]  ctl_sync;

   // write channel state
   logic [ADDR_W-1:0] aw_addr;
   logic              aw_full;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              w_full;

   // registers and port state
   logic [7:0] cfg;
   logic [7:0] pin_config;
   logic [7:0] pin_out;
   logic [1:0] int_status;
   logic [1:0] int_mask;
   logic [7:0] out_latch [3];
   logic [7:0] in_latch [3];
   logic       out_valid;
   logic       in_space;
   logic       read_seen;
   logic       write_seen;

   // bus decode
   wire logic [3:0] wdec      = decode(aw_addr);
   wire logic [3:0] rdec      = decode(s_axi_araddr);
   wire logic       wr_fire   = aw_full & w_full & ~s_axi_bvalid;
   wire logic       wr_lane0  = wr_fire & wdec[3] & w_strb[0];
   wire logic [7:0] wr_byte   = w_data[7:0];
   wire logic       rd_fire   = s_axi_arvalid & s_axi_arready;
   wire logic       wr_cfg    = wr_lane0 & (wdec[2:0] == IDX_CONFIG);
   wire logic       wr_port0  = wr_lane0 & (wdec[2:0] == IDX_PORT0);
   wire logic       wr_port1  = wr_lane0 & (wdec[2:0] == IDX_PORT1);
   wire logic       wr_port2  = wr_lane0 & (wdec[2:0] == IDX_PORT2);
   wire logic       wr_pcfg   = wr_lane0 & (wdec[2:0] == IDX_PIN_CONFIG);
   wire logic       wr_pout   = wr_lane0 & (wdec[2:0] == IDX_PIN_OUT);
   wire logic       wr_mask   = wr_lane0 & (wdec[2:0] == IDX_INT_MASK);
   wire logic       rd_port0  = rd_fire & rdec[3] & (rdec[2:0] == IDX_PORT0);
   wire logic       rd_status = rd_fire & rdec[3] & (rdec[2:0] == IDX_INT_STATUS);

   // port side decode
   wire logic       enabled    = cfg[CFG_ENABLE_BIT];
   wire logic [1:0] width      = cfg[CFG_WIDTH_LSB +: 2];
   wire logic       ov_pol     = cfg[CFG_OV_POL_BIT];
   wire logic       is_pol     = cfg[CFG_IS_POL_BIT];
   wire logic       strobe_lo  = ~ctl_sync[0];
   wire logic       oe_lo      = ~ctl_sync[1];
   wire logic       sel_lo     = ~ctl_sync[2];
   wire logic       read_act   = enabled & oe_lo & sel_lo;                       // [R8] [R13]
   wire logic       write_act  = enabled & strobe_lo & sel_lo;                   // [R8] [R15]
   wire logic       read_done  = read_seen & ~oe_lo;                             // [R14]
   wire logic       write_done = write_seen & ~strobe_lo;                        // [R16]
   wire logic [2:0] lanes      = (width == WIDTH_8)  ? 3'b001 :
                                 (width == WIDTH_16) ? 3'b011 : 3'b111;          // [R1] [R19]

   // next values
   wire logic       next_out_valid = wr_port0 | (out_valid & ~read_act);        // [R9] [R17]
   wire logic       next_in_space  = rd_port0 | (in_space & ~write_act);         // [R10] [R18]
   wire logic [1:0] next_status    = {write_done, read_done} |
                                     (rd_status ? 2'b00 : int_status);
   wire logic [1:0] next_mask      = wr_mask ? wr_byte[1:0] : int_mask;
   wire logic [7:0] next_cfg       = wr_cfg ? (wr_byte & CFG_WRITE_MASK) : cfg;
   wire logic [7:0] next_pcfg      = wr_pcfg ? wr_byte : pin_config;
   wire logic [7:0] next_pout      = wr_pout ? wr_byte : pin_out;
   wire logic       next_en        = next_cfg[CFG_ENABLE_BIT];
   wire logic       next_is_pin    = next_cfg[CFG_IS_POL_BIT] ? ~next_in_space : next_in_space;   // [R12]
   wire logic       next_ov_pin    = next_cfg[CFG_OV_POL_BIT] ? ~next_out_valid : next_out_valid; // [R11]

   // read data mux
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      unique case (rdec[2:0])
         IDX_CONFIG:     rd_byte = {cfg[7:4], ~(is_pol ? ~in_space : in_space),
                                    ~(ov_pol ? ~out_valid : out_valid), cfg[1:0]};  // [R11] [R12]
         IDX_PORT0:      rd_byte = in_latch[0];
         IDX_PORT1:      rd_byte = in_latch[1];
         IDX_PORT2:      rd_byte = in_latch[2];
         IDX_PIN_CONFIG: rd_byte = pin_config;
         IDX_PIN_OUT:    rd_byte = pin_out;
         IDX_INT_STATUS: rd_byte = {6'b00_0000, int_status};
         IDX_INT_MASK:   rd_byte = {6'b00_0000, int_mask};
      endcase
   end

   // synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_meta <= 24'h00_0000;
         data_sync <= 24'h00_0000;
         ctl_meta  <= 3'b111;
         ctl_sync  <= 3'b111;
      end else if (clk_en) begin
         data_meta <= data_in;
         data_sync <= data_meta;
         ctl_meta  <= {select_n, read_enable_n, write_strobe_n};
         ctl_sync  <= ctl_meta;
      end
   end

   // write address and data channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_full <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_full <= 1'b1;
         end
         s_axi_awready <= ~(aw_full | (s_axi_awvalid & s_axi_awready)) & ~s_axi_bvalid;
         s_axi_wready  <= ~(w_full | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
         if (wr_fire) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wdec[3] ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdec[3] ? rd_byte : 8'h00};
            s_axi_rresp  <= rdec[3] ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // configuration, flags and interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg        <= CFG_RESET;
         pin_config <= PIN_CONFIG_RESET;
         pin_out    <= PIN_OUT_RESET;
         int_status <= IRQ_RESET;
         int_mask   <= IRQ_RESET;
         out_valid  <= 1'b0;
         in_space   <= 1'b0;
         read_seen  <= 1'b0;
         write_seen <= 1'b0;
         irq        <= 1'b0;
      end else if (clk_en) begin
         cfg        <= next_cfg;
         pin_config <= next_pcfg;
         pin_out    <= next_pout;
         int_status <= next_status;                                              // [R14] [R16]
         int_mask   <= next_mask;
         out_valid  <= next_out_valid;
         in_space   <= next_in_space;
         read_seen  <= read_act | (read_seen & oe_lo);
         write_seen <= write_act | (write_seen & strobe_lo);
         irq        <= |(next_status & next_mask);
      end
   end

   // data latches, each byte lane on its own
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 3; i++) begin
            out_latch[i] <= 8'h00;
            in_latch[i]  <= 8'h00;
         end
      end else if (clk_en) begin
         if (wr_port0) out_latch[0] <= wr_byte;                                  // [R19]
         if (wr_port1) out_latch[1] <= wr_byte;
         if (wr_port2) out_latch[2] <= wr_byte;
         for (int i = 0; i < 3; i++) begin
            if (write_act & lanes[i]) in_latch[i] <= data_sync[8*i +: 8];        // [R6] [R15]
         end
      end
   end

   // pin drivers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_out              <= 24'h00_0000;
         data_oe               <= 24'h00_0000;
         input_space_flag_pin  <= 1'b0;
         input_space_flag_oe   <= 1'b0;
         output_valid_flag_pin <= 1'b0;
         output_valid_flag_oe  <= 1'b0;
         input_pulldown_en     <= 3'b000;
      end else if (clk_en) begin
         data_out <= {out_latch[2], out_latch[1], out_latch[0]};
         for (int i = 0; i < 3; i++) begin
            data_oe[8*i +: 8] <= {8{read_act & lanes[i]}};                       // [R7] [R13]
         end
         if (next_en) begin
            input_space_flag_pin  <= next_is_pin;                                // [R4] [R2]
            input_space_flag_oe   <= 1'b1;                                       // [R3]
            output_valid_flag_pin <= next_ov_pin;                                // [R5]
            output_valid_flag_oe  <= 1'b1;
            input_pulldown_en     <= 3'b000;
         end else begin
            input_space_flag_pin  <= next_pout[2];
            input_space_flag_oe   <= next_pcfg[2];
            output_valid_flag_pin <= next_pout[3];
            output_valid_flag_oe  <= next_pcfg[3];
            input_pulldown_en     <= {3{next_pcfg[PIN_PD_BIT]}};
         end
      end
   end

   // checks
   a_ov_set_port0: assert property (@(posedge aclk) disable iff (!aresetn)   // [R9]
      clk_en && wr_port0 |=> out_valid)
      else $error("output valid not set by port 0 write");
   a_ov_cleared_read: assert property (@(posedge aclk) disable iff (!aresetn)   // [R9]
      clk_en && read_act && !wr_port0 |=> !out_valid)
      else $error("output valid not cleared by external read");
   a_is_cleared_strobe: assert property (@(posedge aclk) disable iff (!aresetn)   // [R15]
      clk_en && write_act && !rd_port0 |=> !in_space)
      else $error("input space not cleared by strobe");
   a_ov_pin_pol: assert property (@(posedge aclk) disable iff (!aresetn)   // [R11]
      enabled |-> output_valid_flag_pin == (ov_pol ? !out_valid : out_valid))
      else $error("output valid pin polarity wrong");
   a_is_pin_pol: assert property (@(posedge aclk) disable iff (!aresetn)   // [R12]
      enabled |-> input_space_flag_pin == (is_pol ? !in_space : in_space))
      else $error("input space pin polarity wrong");
   a_select_gates: assert property (@(posedge aclk) disable iff (!aresetn)   // [R8]
      clk_en && ctl_sync[2] |=> data_oe == 24'h00_0000 && $stable(in_latch[0]))
      else $error("select did not gate the port");
   a_width_drive: assert property (@(posedge aclk) disable iff (!aresetn)   // [R1]
      clk_en && read_act && width == WIDTH_8 |=> data_oe == 24'h00_00FF)
      else $error("8-bit read drove wrong lanes");
   a_read_irq: assert property (@(posedge aclk) disable iff (!aresetn)   // [R14]
      clk_en && read_seen && !oe_lo && int_mask[IRQ_READ_BIT] |=> int_status[IRQ_READ_BIT] ##1 irq || !clk_en)
      else $error("read completion did not interrupt");
   a_write_latch: assert property (@(posedge aclk) disable iff (!aresetn)   // [R6]
      clk_en && write_act |=> in_latch[0] == $past(data_sync[7:0]))
      else $error("strobe did not latch data");
   a_enabled_pp: assert property (@(posedge aclk) disable iff (!aresetn)   // [R3]
      clk_en && next_en |=> input_space_flag_oe && output_valid_flag_oe && input_pulldown_en == 3'b000)
      else $error("enabled port pins not in port mode");
   a_wr_done_flag: assert property (   // [R16]
      clk_en && write_done |=> int_status[IRQ_WRITE_BIT])
      else $error("write completion not flagged");
   a_is_set_port0: assert property (   // [R10] [R18]
      clk_en && rd_port0 |=> in_space)
      else $error("input space not set by port 0 read");
   a_ov_status_opp: assert property (   // [R11]
      enabled && rdec == {1'b1, IDX_CONFIG} |-> rd_byte[CFG_OV_BIT] != output_valid_flag_pin)
      else $error("output valid status not opposite to pin");
   a_is_status_opp: assert property (   // [R12]
      enabled && rdec == {1'b1, IDX_CONFIG} |-> rd_byte[CFG_IS_BIT] != input_space_flag_pin)
      else $error("input space status not opposite to pin");
   a_full_lanes: assert property (   // [R1] [R19]
      clk_en && read_act && lanes == 3'b111 |=> data_oe == 24'hFF_FFFF)
      else $error("24-bit read drove wrong lanes");
   a_disabled_idle: assert property (   // [R13]
      clk_en && !enabled |=> data_oe == 24'h00_0000)
      else $error("disabled port drove data pins");
   a_irq_level: assert property (   // [R14] [R16]
      irq == (|(int_status & int_mask)))
      else $error("interrupt level does not follow status and mask");
   a_status_clear: assert property (   // [R14] [R16]
      clk_en && rd_status && !read_done && !write_done |=> int_status == 2'b00)
      else $error("status read did not clear events");
   a_upper_latch: assert property (   // [R19]
      clk_en && write_act && lanes[2] |=> in_latch[2] == $past(data_sync[23:16]))
      else $error("upper lane not latched");
   c_read_done: cover property (@(posedge aclk) disable iff (!aresetn) read_done);
   c_write_done: cover property (@(posedge aclk) disable iff (!aresetn) write_done);
   c_wide_read: cover property (@(posedge aclk) disable iff (!aresetn) read_act && lanes == 3'b111);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
   c_frozen: cover property (!clk_en && out_valid);

endmodule : assisted_parallel_port

// ===== ext_host.sv
module ext_host (
   input  wire logic        aclk,
   output logic             write_strobe_n,
   output logic             read_enable_n,
   output logic             select_n,
   output logic [23:0]      host_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      write_strobe_n = 1'b1;
      read_enable_n  = 1'b1;
      select_n       = 1'b1;
      host_data      = 24'h00_0000;
   end

   // one access: data first, then the active low controls for a fixed hold
   task automatic access(input logic sel_n, input logic rd_n, input logic wr_n, input logic [23:0] d);
      @(posedge aclk);
      host_data      <= d;
      @(posedge aclk);
      select_n       <= sel_n;
      read_enable_n  <= rd_n;
      write_strobe_n <= wr_n;
      repeat (6) @(posedge aclk);
      select_n       <= 1'b1;
      read_enable_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      repeat (3) @(posedge aclk);
      // released lines show the inverse of the last value
      host_data      <= ~d;
   endtask : access
endmodule : ext_host

// ===== test_assisted_parallel_port.sv
module test_assisted_parallel_port
   import parallel_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]       s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0]        s_axi_wstrb = 4'hF;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic [23:0]       data_in, data_out, data_oe, host_data;
   logic              write_strobe_n, read_enable_n, select_n, irq;
   logic              input_space_flag_pin, input_space_flag_oe, output_valid_flag_pin, output_valid_flag_oe;
   logic [2:0]        input_pulldown_en;
   logic [34:0]       rd_q[$];
   logic [47:0]       ext_q[$];
   logic [34:0]       exp_r;
   logic [47:0]       exp_e;
   logic              prev_oe = 1'b0;
   logic              clk_en = 1'b1;
   int                bad_count = 0;
   int                check_count = 0;

   always #20 aclk = ~aclk;
   assign data_in = (data_out & data_oe) | (host_data & ~data_oe);

   assisted_parallel_port dut (
      .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_in, .data_out, .data_oe,
      .write_strobe_n, .read_enable_n, .select_n, .input_space_flag_pin, .input_space_flag_oe,
      .output_valid_flag_pin, .output_valid_flag_oe, .input_pulldown_en, .irq);

   ext_host host (.aclk, .write_strobe_n, .read_enable_n, .select_n, .host_data);

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      check(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er, input logic chk);
      rd_q.push_back({chk, er, 24'h00_0000, v});
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready  <= 1'b0;
   endtask : axi_read

   // result watcher: register reads and data lanes driven to the pins
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rd_q.size() > 0) begin
         exp_r = rd_q.pop_front();
         if (exp_r[34]) check({s_axi_rresp, s_axi_rdata}, exp_r[33:0]);
      end
      if (data_oe[0] === 1'b1 && prev_oe !== 1'b1) begin
         if (ext_q.size() > 0) begin
            exp_e = ext_q.pop_front();
            check({data_oe, data_out & data_oe}, exp_e);
         end
         else check(data_oe, 24'h00_0000);
      end
      prev_oe <= data_oe[0];
   end

   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      stop_test();
   end

   initial begin
      logic [1:0]  w;
      logic [1:0]  msk;
      logic        ovp;
      logic        isp;
      logic [7:0]  cfg;
      logic [23:0] d;
      logic [23:0] lanes;
      void'($urandom(96));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_write(OFF_PIN_OUT, 32'h0000_0008, RESP_OKAY);
      s_axi_wstrb <= 4'hE;
      axi_write(OFF_PIN_OUT, 32'h0000_00FF, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axi_write(OFF_PIN_CONFIG, 32'h0000_0084, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({output_valid_flag_oe, output_valid_flag_pin, input_pulldown_en}, 5'h0F);
      check({input_space_flag_oe, input_space_flag_pin}, 2'b10);
      axi_read(OFF_PIN_OUT, 8'h08, RESP_OKAY, 1'b1);
      axi_write(8'h20, 32'h0000_00FF, RESP_SLVERR);
      axi_read(8'h20, 8'h00, RESP_SLVERR, 1'b1);
      for (int i = 0; i < 4; i++) begin
         w     = 2'(i);
         ovp   = 1'($urandom);
         isp   = 1'($urandom);
         msk   = 2'($urandom);
         lanes = (w == WIDTH_8) ? 24'h00_00FF : (w == WIDTH_16) ? 24'h00_FFFF : 24'hFF_FFFF;
         cfg   = {2'b01, isp, ovp, 2'b00, w};
         axi_write(OFF_INT_MASK, {30'h0000_0000, msk}, RESP_OKAY);
         axi_write(OFF_CONFIG, {24'h00_0000, cfg}, RESP_OKAY);
         axi_read(OFF_PORT0, 8'h00, RESP_OKAY, 1'b0);
         axi_read(OFF_CONFIG, cfg | {4'h0, isp, ~ovp, 2'b00}, RESP_OKAY, 1'b1);
         check({output_valid_flag_oe, input_space_flag_oe, input_pulldown_en}, 5'b11000);
         check(input_space_flag_pin, !isp);
         d = 24'($urandom);
         axi_write(OFF_PORT2, {24'h00_0000, d[23:16]}, RESP_OKAY);
         axi_write(OFF_PORT1, {24'h00_0000, d[15:8]}, RESP_OKAY);
         check(output_valid_flag_pin, ovp);
         axi_write(OFF_PORT0, {24'h00_0000, d[7:0]}, RESP_OKAY);
         repeat (2) @(posedge aclk);
         check(output_valid_flag_pin, !ovp);
         ext_q.push_back({lanes, d & lanes});
         host.access(1'b0, 1'b0, 1'b1, ~host_data);
         repeat (4) @(posedge aclk);
         check({irq, output_valid_flag_pin}, {msk[0], ovp});
         axi_read(OFF_INT_STATUS, 8'h01, RESP_OKAY, 1'b1);
         repeat (2) @(posedge aclk);
         check(irq, 1'b0);
         d = 24'($urandom);
         host.access(1'b0, 1'b1, 1'b0, d);
         repeat (4) @(posedge aclk);
         check({irq, input_space_flag_pin}, {msk[1], isp});
         axi_read(OFF_INT_STATUS, 8'h02, RESP_OKAY, 1'b1);
         if (w != WIDTH_8 && w != WIDTH_16) axi_read(OFF_PORT2, d[23:16], RESP_OKAY, 1'b1);
         if (w != WIDTH_8) axi_read(OFF_PORT1, d[15:8], RESP_OKAY, 1'b1);
         check(input_space_flag_pin, isp);
         axi_read(OFF_PORT0, d[7:0], RESP_OKAY, 1'b1);
         repeat (2) @(posedge aclk);
         check(input_space_flag_pin, !isp);
      end
      axi_write(OFF_PORT0, 32'h0000_005A, RESP_OKAY);
      clk_en <= 1'b0;
      host.access(1'b0, 1'b0, 1'b1, 24'h00_0000);
      clk_en <= 1'b1;
      repeat (4) @(posedge aclk);
      check({irq, data_oe, output_valid_flag_pin}, {25'h000_0000, !ovp});
      host.access(1'b1, 1'b0, 1'b0, 24'hA5_5A5A);
      repeat (4) @(posedge aclk);
      check({irq, data_oe, output_valid_flag_pin}, {25'h000_0000, !ovp});
      axi_read(OFF_INT_STATUS, 8'h00, RESP_OKAY, 1'b1);
      stop_test();
   end
endmodule : test_assisted_parallel_port
